/* shared/sar_adc_pkg.sv */
// Shared constants and types of the converter sequencer.
package sar_adc_pkg;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  // Machine clock period in ns (100 MHz).
  localparam int CLK_PERIOD_NS = 10;
  // Least sampling time in ns (2.0 us).
  localparam int SAMPLE_TIME_NS = 2000;
  // Least time for a whole channel, sampling included, in ns (6.12 us).
  localparam int CONV_TIME_NS = 6120;
  // Least times round up to whole cycles.
  localparam int SAMPLE_CYC_I =
    (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYC_I =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Full resolution in bits and the reduced one.
  localparam int RES_HI_BITS = 10;
  localparam int RES_LO_BITS = 8;
  // Cycles per decided bit; ten bits fit behind the sampling phase.
  localparam int BIT_CYC_I = (CONV_CYC_I - SAMPLE_CYC_I) / RES_HI_BITS;
  localparam logic [9:0] SAMPLE_CYC = SAMPLE_CYC_I[9:0];
  localparam logic [9:0] CONV_CYC   = CONV_CYC_I[9:0];
  localparam logic [5:0] BIT_CYC    = BIT_CYC_I[5:0];

  // ---------------------------------------------------------------------
  // Approximation codes
  // ---------------------------------------------------------------------
  // First trial code, the half-scale bit.
  localparam logic [9:0] SAR_MSB  = 10'h200;
  // Mask of the last decided bit at 10 and at 8 bits.
  localparam logic [9:0] LAST_HI  = 10'h001;
  localparam logic [9:0] LAST_LO  = 10'h004;
  // Reset values.
  localparam logic [9:0] CODE_RST = 10'h000;
  localparam logic [2:0] CH_RST   = 3'h0;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  // Sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SAMP  = 4'b0010,
    ST_CONV  = 4'b0100,
    ST_PAUSE = 4'b1000
  } seq_state_t;

  // Channel stepping modes.
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_CONT   = 2'h1,
    MODE_PAUSE  = 2'h2
  } conv_mode_t;

  // Start sources.
  typedef enum logic [1:0] {
    TRIG_SOFT  = 2'h0,
    TRIG_TIMER = 2'h1,
    TRIG_EXT   = 2'h2
  } trig_src_t;

  // Software configuration, held steady while converting.
  typedef struct packed {
    conv_mode_t mode;
    trig_src_t  trig_sel;
    logic [2:0] start_ch;
    logic [2:0] end_ch;
    logic       res10;
    logic       int_en;
    logic       xfer_en;
  } adc_cfg_t;

endpackage : sar_adc_pkg

/* design/sar_bit_engine.sv */
// Successive-approximation register that decides one bit per step.
`timescale 1ns/100ps
`default_nettype none
module sar_bit_engine
  import sar_adc_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rstn,
  // Control from the sequencer.
  input  wire logic       load,
  input  wire logic       step,
  input  wire logic       res10,
  // Comparator, high when the held input is at or above the trial code.
  input  wire logic       cmp_hi,
  // Trial code driving the converter's reference.
  output logic [9:0]      trial,
  output logic            fin
);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [9:0] trial;  // Current trial code.
    logic [9:0] mask;   // Bit under decision.
    logic       fin;    // All bits decided.
  } sar_st_t;

  sar_st_t s_r;   // Registered state.
  sar_st_t s_nxt; // Next state.

  // Each step before fin keeps or drops the bit under test, then tries the next one unless it was the last.
  always_comb
  begin
    s_nxt = s_r;
    if (load)
    begin
      s_nxt.trial = SAR_MSB;
      s_nxt.mask  = SAR_MSB;
      s_nxt.fin   = 1'b0;
    end
    else if (step && !s_r.fin)
    begin
      // A low comparator means the trial overshot the input.
      if (!cmp_hi)
        s_nxt.trial = s_r.trial & ~s_r.mask;
      s_nxt.mask = s_r.mask >> 1;
      // The 8-bit setting stops two bits early.
      if (s_r.mask == (res10 ? LAST_HI : LAST_LO))
        s_nxt.fin = 1'b1;
      else
        s_nxt.trial = s_nxt.trial | (s_r.mask >> 1);
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign trial = s_r.trial;
  assign fin   = s_r.fin;

  // A dropped bit is cleared from the trial code on the next cycle.
  a_bit_decide: assert property (
    @(posedge clk) disable iff (!rstn)
    step && !s_r.fin && !load && !cmp_hi && s_r.mask != LAST_HI
    |=> (trial & $past(s_r.mask)) == 10'h000)
    else $error("dropped bit still set in trial code");

endmodule : sar_bit_engine
`default_nettype wire

/* design/sar_adc_sequencer.sv */
// Channel sequencer and conversion timing of the 8/10-bit converter.
//
// Contract
// - Result width is 8 or 10 bits.
// - Any of eight input channels is selectable.
// - A channel takes at least 6.12 us.
// - Sampling lasts at least 2.0 us.
// - Bits decided by successive approximation.
// - Stored result may raise an enabled interrupt.
// - That interrupt may start the transfer service.
// - Start by software, timer or external fall.
// - Single mode halts after the end channel.
// - Continuous mode wraps to the start channel.
// - Pausing mode stops after every channel.
`timescale 1ns/100ps
`default_nettype none
module sar_adc_sequencer
(
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // Configuration.
  input  wire sar_adc_pkg::adc_cfg_t cfg,
  // Start sources and control strobes.
  input  wire logic                  soft_trig,
  input  wire logic                  timer_trig,
  input  wire logic                  ext_trig,
  input  wire logic                  stop_req,
  input  wire logic                  clr_done,
  // Analog front end.
  input  wire logic                  cmp_hi,
  output logic [2:0]                 chan_sel,
  output logic                       sample_en,
  output logic [9:0]                 dac_code,
  // Results and events.
  output logic [9:0]                 result,
  output logic [2:0]                 result_ch,
  output logic                       done_flag,
  output logic                       irq_req,
  output logic                       xfer_req,
  output logic                       busy
);
  import sar_adc_pkg::*;

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    seq_state_t st;        // Sequencer state.
    logic [2:0] ch;        // Channel being or next to be converted.
    logic [9:0] cnt;       // Cycles since the channel started.
    logic [5:0] btmr;      // Cycles within the current bit.
    logic [9:0] result;    // Last stored result.
    logic [2:0] result_ch; // Channel of the last result.
    logic       done;      // Sticky result-stored flag.
    logic       irq;       // Interrupt request.
    logic       xfer;      // Transfer service start pulse.
    logic       busy;      // A sequence is active.
    logic       samp;      // Sample switch closed.
    logic       ext_prev;  // Previous external trigger level.
  } seq_st_t;

  seq_st_t    s_r;   // Registered state.
  seq_st_t    s_nxt; // Next state.
  logic       load;  // Arms the approximation register.
  logic       step;  // Decides one bit.
  logic       store; // Result is taken this cycle.
  logic       trig;  // Selected start source fired.
  logic [9:0] trial; // Code under trial.
  logic       fin;   // All bits decided.

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  // Picks the one start source that software selected.
  function automatic logic trig_pick(input trig_src_t sel,
                                     input logic sw, input logic tm,
                                     input logic ef);
    case (sel)
      TRIG_SOFT:  trig_pick = sw;
      TRIG_TIMER: trig_pick = tm;
      TRIG_EXT:   trig_pick = ef;
      default:    trig_pick = 1'b0;
    endcase
  endfunction : trig_pick
  // Next channel in the sequence, wrapping at the end channel.
  function automatic logic [2:0] ch_next(input logic [2:0] ch,
                                         input logic [2:0] first,
                                         input logic [2:0] last);
    ch_next = (ch == last) ? first : ch + 3'h1;
  endfunction : ch_next

  // ---------------------------------------------------------------------
  // Approximation register
  // ---------------------------------------------------------------------
  sar_bit_engine u_sar (
    .clk    (clk),
    .rstn   (rstn),
    .load   (load),
    .step   (step),
    .res10  (cfg.res10),
    .cmp_hi (cmp_hi),
    .trial  (trial),
    .fin    (fin)
  );

  // ---------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------
  // The external source counts only on a high-to-low step.
  assign trig = trig_pick(cfg.trig_sel, soft_trig, timer_trig,
                          s_r.ext_prev & ~ext_trig);
  // One pass through here per cycle; a stop request beats every state change, but a store in the same cycle still lands.
  always_comb
  begin
    s_nxt          = s_r;
    s_nxt.xfer     = 1'b0;
    s_nxt.ext_prev = ext_trig;
    load           = 1'b0;
    step           = 1'b0;
    store          = 1'b0;
    // Software clear first, so a store in the same cycle wins.
    if (clr_done)
      s_nxt.done = 1'b0;
    case (s_r.st)
      ST_IDLE:
      begin
        // A fresh sequence begins at the start channel.
        if (trig)
        begin
          s_nxt.ch = cfg.start_ch;
          load     = 1'b1;
        end
      end
      ST_PAUSE:
      begin
        // Resume with the channel already advanced to.
        if (trig)
          load = 1'b1;
      end
      ST_SAMP:
      begin
        s_nxt.cnt = s_r.cnt + 10'h001;
        // Hold the switch closed for the full sampling time.
        if (s_r.cnt == SAMPLE_CYC - 10'h001)
        begin
          s_nxt.st   = ST_CONV;
          s_nxt.samp = 1'b0;
        end
      end
      ST_CONV:
      begin
        s_nxt.cnt  = s_r.cnt + 10'h001;
        s_nxt.btmr = s_r.btmr + 6'h01;
        // Each bit gets its settling time before it is decided.
        if (s_r.btmr == BIT_CYC - 6'h01)
        begin
          s_nxt.btmr = 6'h00;
          step       = !fin;
        end
        // The channel ends only when its least time is up.
        if (s_r.cnt == CONV_CYC - 10'h001)
          store = 1'b1;
      end
      default:
      begin
        s_nxt.st   = ST_IDLE;
        s_nxt.busy = 1'b0;
        s_nxt.samp = 1'b0;
      end
    endcase
    if (store)
    begin
      // Result, flag and requests land on the same edge.
      s_nxt.result    = cfg.res10 ? trial : {2'h0, trial[9:2]};
      s_nxt.result_ch = s_r.ch;
      s_nxt.done      = 1'b1;
      s_nxt.xfer      = cfg.int_en & cfg.xfer_en;
      s_nxt.ch        = ch_next(s_r.ch, cfg.start_ch, cfg.end_ch);
      case (cfg.mode)
        MODE_SINGLE:
        begin
          // The end channel finishes the pass.
          if (s_r.ch == cfg.end_ch)
          begin
            s_nxt.st   = ST_IDLE;
            s_nxt.busy = 1'b0;
          end
          else
            load = 1'b1;
        end
        MODE_CONT:   load = 1'b1;
        MODE_PAUSE:  s_nxt.st = ST_PAUSE;
        default:
        begin
          s_nxt.st   = ST_IDLE;
          s_nxt.busy = 1'b0;
        end
      endcase
    end
    // Every channel start resets the timers and closes the switch.
    if (load)
    begin
      s_nxt.st   = ST_SAMP;
      s_nxt.cnt  = 10'h000;
      s_nxt.btmr = 6'h00;
      s_nxt.samp = 1'b1;
      s_nxt.busy = 1'b1;
    end
    if (stop_req)
    begin
      s_nxt.st   = ST_IDLE;
      s_nxt.samp = 1'b0;
      s_nxt.busy = 1'b0;
    end
    // The request follows the flag, gated by the enable.
    s_nxt.irq = s_nxt.done & cfg.int_en;
  end
  // State register; the external level resets high so no false fall.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_r          <= '0;
      s_r.st       <= ST_IDLE;
      s_r.ch       <= CH_RST;
      s_r.result   <= CODE_RST;
      s_r.ext_prev <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end
  // All outputs come from flip-flops.
  assign chan_sel  = s_r.ch;
  assign sample_en = s_r.samp;
  assign dac_code  = trial;
  assign result    = s_r.result;
  assign result_ch = s_r.result_ch;
  assign done_flag = s_r.done;
  assign irq_req   = s_r.irq;
  assign xfer_req  = s_r.xfer;
  assign busy      = s_r.busy;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_stored;
    store && !stop_req;
  endsequence
  sequence s_resumed;
    s_r.st == ST_SAMP && sample_en;
  endsequence
  a_sample_len: assert property (
    s_r.st == ST_SAMP && s_nxt.st == ST_CONV |-> s_r.cnt == 10'd199)
    else $error("sampling phase shorter than required");
  a_conv_len: assert property (
    store |-> s_r.cnt == 10'd611 && s_r.st == ST_CONV && fin)
    else $error("channel finished before its least time");
  a_store_same: assert property (
    store |=> done_flag && result_ch == $past(s_r.ch)
              && result == $past(cfg.res10 ? trial : {2'h0, trial[9:2]}))
    else $error("result not stored with the flag");
  a_irq_gate: assert property (
    $rose(done_flag) && $past(cfg.int_en) |-> irq_req)
    else $error("enabled interrupt missing on result store");
  a_xfer_pulse: assert property (
    xfer_req |-> irq_req ##1 !xfer_req)
    else $error("transfer start not a single-cycle pulse");
  a_res_narrow: assert property (
    store && !cfg.res10 |=> result[9:8] == 2'h0)
    else $error("8-bit result has upper bits set");
  a_single_halt: assert property (
    s_stored and (cfg.mode == MODE_SINGLE && s_r.ch == cfg.end_ch)
    |=> s_r.st == ST_IDLE && !busy)
    else $error("single pass did not halt at end channel");
  a_cont_wrap: assert property (
    s_stored and (cfg.mode == MODE_CONT && s_r.ch == cfg.end_ch)
    |=> s_resumed and chan_sel == $past(cfg.start_ch))
    else $error("continuous pass did not wrap to start");
  a_pause_stop: assert property (
    s_stored and (cfg.mode == MODE_PAUSE)
    |=> s_r.st == ST_PAUSE && !sample_en && busy
    ##1 (s_r.st == ST_PAUSE || s_r.st == ST_SAMP || s_r.st == ST_IDLE))
    else $error("pausing mode did not pause after channel");
  a_pause_resume: assert property (
    s_r.st == ST_PAUSE && trig && !stop_req
    |=> s_resumed and chan_sel == $past(s_r.ch))
    else $error("pause resume changed the channel");
  a_ext_fall: assert property (
    s_r.st == ST_IDLE && cfg.trig_sel == TRIG_EXT && !stop_req
    && s_r.ext_prev && !ext_trig
    |=> s_resumed ##1 (sample_en || $past(stop_req)))
    else $error("external falling edge did not start");
endmodule : sar_adc_sequencer
`default_nettype wire

/* tb/analog_front_model.sv */
// Behavioural model of the analog inputs and the comparator.
`timescale 1ns/100ps
`default_nettype none
module analog_front_model
(
  // Clock.
  input  wire logic       clk,
  // Selector and trial code from the sequencer.
  input  wire logic [2:0] chan_sel,
  input  wire logic       sample_en,
  input  wire logic [9:0] dac_code,
  // Comparator decision.
  output logic            cmp_hi
);
  // ---------------------------------------------------------------------
  // Sample and hold
  // ---------------------------------------------------------------------
  // Held level; each channel has its own fixed input level.
  logic [9:0] held_r = 10'h000;

  // The switch tracks the selected input only while it is closed, so a
  // sequencer that decides bits too early sees a stale level.
  always @(posedge clk)
  begin
    if (sample_en === 1'b1)
    begin
      held_r <= 10'h05B + {7'h00, chan_sel} * 10'h071;
    end
  end

  // High when the held level is at or above the trial code.
  assign cmp_hi = (held_r >= dac_code);
endmodule : analog_front_model
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench of the converter sequencer.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import sar_adc_pkg::*;
  // ---------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------
  logic       clk        = 1'b0;
  logic       rstn       = 1'b0;
  adc_cfg_t   cfg        = '0;
  logic       soft_trig  = 1'b0;
  logic       timer_trig = 1'b0;
  logic       ext_trig   = 1'b1;
  logic       stop_req   = 1'b0;
  logic       clr_done   = 1'b0;
  logic       cmp_hi;
  logic [2:0] chan_sel;
  logic       sample_en;
  logic [9:0] dac_code;
  logic [9:0] result;
  logic [2:0] result_ch;
  logic       done_flag;
  logic       irq_req;
  logic       xfer_req;
  logic       busy;
  int         mismatches = 0;
  int         cmp_count  = 0;
  int         cyc        = 0;   // Free-running cycle count.
  int         last_store = 0;   // Cycle of the previous store.
  int         run        = 0;   // Length of the current sampling.
  int         sample_len = 0;   // Length of the last sampling.

  // The clock toggles every half period of 5 ns.
  always #5 clk = ~clk;

  sar_adc_sequencer dut (.clk(clk), .rstn(rstn), .cfg(cfg),
    .soft_trig(soft_trig), .timer_trig(timer_trig), .ext_trig(ext_trig),
    .stop_req(stop_req), .clr_done(clr_done), .cmp_hi(cmp_hi),
    .chan_sel(chan_sel), .sample_en(sample_en), .dac_code(dac_code),
    .result(result), .result_ch(result_ch), .done_flag(done_flag),
    .irq_req(irq_req), .xfer_req(xfer_req), .busy(busy));

  analog_front_model afe (.clk(clk), .chan_sel(chan_sel),
    .sample_en(sample_en), .dac_code(dac_code), .cmp_hi(cmp_hi));

  // Counts cycles and measures each sampling phase as it ends.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (sample_en === 1'b1)
    begin
      run <= run + 1;
    end
    else if (run != 0)
    begin
      sample_len <= run;
      run <= 0;
    end
  end

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  // Compares one value; four-state so an unknown never matches.
  task automatic check(input string what, input logic [9:0] exp,
                       input logic [9:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Result code of a channel, worked out from the input levels.
  function automatic logic [9:0] exp_code(input logic [2:0] ch,
                                          input logic       r10);
    logic [9:0] v;
    v = 10'h05B + {7'h00, ch} * 10'h071;
    return r10 ? v : {2'h0, v[9:2]};
  endfunction : exp_code

  // Sets the configuration between passes.
  task automatic set_cfg(input conv_mode_t m, input trig_src_t t,
                         input logic [2:0] s, input logic [2:0] e,
                         input logic r, input logic i, input logic x);
    @(posedge clk);
    cfg <= '{mode: m, trig_sel: t, start_ch: s, end_ch: e,
             res10: r, int_en: i, xfer_en: x};
  endtask : set_cfg

  // One-cycle trigger; the external source is a falling step.
  task automatic fire(input trig_src_t t);
    @(posedge clk);
    soft_trig  <= (t == TRIG_SOFT);
    timer_trig <= (t == TRIG_TIMER);
    ext_trig   <= (t != TRIG_EXT);
    @(posedge clk);
    soft_trig  <= 1'b0;
    timer_trig <= 1'b0;
    ext_trig   <= 1'b1;
  endtask : fire

  // One-cycle stop strobe, then the sequencer must be idle.
  task automatic stop;
    @(posedge clk);
    stop_req <= 1'b1;
    @(posedge clk);
    stop_req <= 1'b0;
    repeat (3) @(posedge clk);
    check("busy after stop", 10'h000, {9'h000, busy});
  endtask : stop

  // Waits for a store, judges it, then clears the flag.
  task automatic store(input logic [2:0] ch, input logic r10,
                       input logic irq, input logic xf, input logic gap);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (done_flag !== 1'b1 && n < 1000);
    if (n >= 1000)
    begin
      mismatches++;
      $display("[ERR] store expected 1 seen 0");
      summarize();
    end
    else
    begin
      // The flag was seen, so the stored values stand this cycle.
      check("result", exp_code(ch, r10),
            result);
      check("result_ch", {7'h00, ch}, {7'h00, result_ch});
      check("irq_req", {9'h000, irq}, {9'h000, irq_req});
      check("xfer_req", {9'h000, xf}, {9'h000, xfer_req});
      check("sample len", 10'd200, 10'(sample_len));
      if (gap)
      begin
        check("store gap", 10'd612, 10'(cyc - last_store));
      end
      last_store = cyc;
      clr_done <= 1'b1;
      @(posedge clk);
      clr_done <= 1'b0;
      check("xfer pulse end", 10'h000, {9'h000, xfer_req});
    end
  endtask : store

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  // Single pass over channels 2 to 4 at 10 bits, then halt.
  task automatic t_single;
    set_cfg(MODE_SINGLE, TRIG_SOFT, 3'h2, 3'h4, 1'b1, 1'b1, 1'b1);
    fire(TRIG_SOFT);
    // First sampling cycle: half-scale trial on the start channel.
    @(posedge clk);
    check("trial start", SAR_MSB, dac_code);
    check("chan_sel", 10'h002, {7'h00, chan_sel});
    check("sample_en", 10'h001, {9'h000, sample_en});
    store(3'h2, 1'b1, 1'b1, 1'b1, 1'b0);
    store(3'h3, 1'b1, 1'b1, 1'b1, 1'b1);
    store(3'h4, 1'b1, 1'b1, 1'b1, 1'b1);
    repeat (3) @(posedge clk);
    check("busy at halt", 10'h000, {9'h000, busy});
    check("irq cleared", 10'h000, {9'h000, irq_req});
    repeat (700) @(posedge clk);
    check("no store", 10'h000, {9'h000, done_flag});
  endtask : t_single

  // Timer-started continuous run at 8 bits, wrapping 7 to 5.
  task automatic t_cont;
    set_cfg(MODE_CONT, TRIG_TIMER, 3'h5, 3'h7, 1'b0, 1'b0, 1'b0);
    fire(TRIG_SOFT);
    repeat (5) @(posedge clk);
    check("wrong source", 10'h000, {9'h000, busy});
    fire(TRIG_TIMER);
    store(3'h5, 1'b0, 1'b0, 1'b0, 1'b0);
    store(3'h6, 1'b0, 1'b0, 1'b0, 1'b1);
    store(3'h7, 1'b0, 1'b0, 1'b0, 1'b1);
    store(3'h5, 1'b0, 1'b0, 1'b0, 1'b1);
    stop();
  endtask : t_cont

  // Pausing run on external falls: one channel per trigger, wrapping.
  task automatic t_pause;
    set_cfg(MODE_PAUSE, TRIG_EXT, 3'h0, 3'h1, 1'b1, 1'b1, 1'b0);
    fire(TRIG_TIMER);
    repeat (5) @(posedge clk);
    check("wrong source", 10'h000, {9'h000, busy});
    for (int k = 0; k < 3; k++)
    begin
      fire(TRIG_EXT);
      store(3'(k % 2), 1'b1, 1'b1, 1'b0, 1'b0);
      repeat (700) @(posedge clk);
      check("paused", 10'h000, {9'h000, done_flag});
      check("switch open", 10'h000, {9'h000, sample_en});
      check("busy in pause", 10'h001, {9'h000, busy});
      // The channel has already advanced, wrapping after the end one.
      check("next channel", {7'h00, 3'((k + 1) % 2)},
            {7'h00, chan_sel});
    end
    stop();
  endtask : t_pause

  // ---------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------
  // Reset for 20 cycles, check the idle outputs, run the scenarios.
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check("result at reset", 10'h000, result);
    check("busy at reset", 10'h000, {9'h000, busy});
    t_single();
    t_cont();
    t_pause();
    summarize();
  end

  // Cuts a hung run short; the limit is far above the scenarios' need.
  initial
  begin
    repeat (50000) @(posedge clk);
    mismatches++;
    $display("[ERR] run length expected end seen hang");
    summarize();
  end
endmodule : tb
`default_nettype wire
